// ### shared/sapm_cfg.svh
`ifndef SAPM_CFG_SVH
`define SAPM_CFG_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define SAPM_POS_W 24
`define SAPM_DLY_W 17
`define SAPM_IRQ_W 3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SAPM_CLK_NS 50
`define SAPM_MS_NS 1000000
`define SAPM_MS_CYCLES (`SAPM_MS_NS / `SAPM_CLK_NS)
`define SAPM_DLY_MAX_MS 17'h1D4C0
`define SAPM_DLY_RST_MS 17'h00014

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SAPM_OFF_CTRL 8'h00
`define SAPM_OFF_LOWER 8'h04
`define SAPM_OFF_UPPER 8'h08
`define SAPM_OFF_DELAY 8'h0C
`define SAPM_OFF_TOL 8'h10
`define SAPM_OFF_STATUS 8'h14
`define SAPM_OFF_IRQ_STAT 8'h18
`define SAPM_OFF_IRQ_MASK 8'h1C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SAPM_CTRL_PERM 0
`define SAPM_CTRL_INV 1
`define SAPM_CTRL_MON_ONLY 2
`define SAPM_ST_STATE_LO 0
`define SAPM_ST_ACK 2
`define SAPM_ST_STOP 3
`define SAPM_ST_LIMIT 4
`define SAPM_ST_MISMATCH 5
`define SAPM_ST_ACTIVE 6
`define SAPM_IRQ_LIMIT 0
`define SAPM_IRQ_MISMATCH 1
`define SAPM_IRQ_START 2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SAPM_CTRL_RST 3'h0
`define SAPM_POS_RST 24'h000000
`define SAPM_TOL_RST 24'h000010
`define SAPM_IRQ_RST 3'h0

`endif

// ### shared/sapm_pkg.sv
package sapm_pkg;

  typedef enum logic [1:0]
  {
    SAPM_IDLE = 2'b00,
    SAPM_DELAY = 2'b01,
    SAPM_MON = 2'b10
  } sapm_state_t;

  typedef enum logic [3:0]
  {
    SAPM_R_CTRL = 4'b0000,
    SAPM_R_LOWER = 4'b0001,
    SAPM_R_UPPER = 4'b0010,
    SAPM_R_DELAY = 4'b0011,
    SAPM_R_TOL = 4'b0100,
    SAPM_R_STATUS = 4'b0101,
    SAPM_R_IRQ_STAT = 4'b0110,
    SAPM_R_IRQ_MASK = 4'b0111,
    SAPM_R_NONE = 4'b1111
  } sapm_reg_t;

  typedef logic signed [23:0] sapm_pos_t;

endpackage

// ### hdl/sapm_sync.sv
`timescale 1ns/1ps
module sapm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb
  begin
    meta_next = d_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign d_out = sync_reg;

endmodule

// ### hdl/sapm_delay_timer.sv
`timescale 1ns/1ps
`include "sapm_cfg.svh"
module sapm_delay_timer import sapm_pkg::*; #(
  parameter int MS_CYCLES = `SAPM_MS_CYCLES,
  parameter int DW = `SAPM_DLY_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic [DW-1:0] delay_ms,
  output logic done
);

  localparam int PW = $clog2(MS_CYCLES + 1);

  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic [DW-1:0] ms_reg;
  logic [DW-1:0] ms_next;

  // Zero delay is done at once
  assign done = (ms_reg >= delay_ms);

  always_comb
  begin
    pre_next = pre_reg;
    ms_next = ms_reg;
    if (clear)
    begin
      pre_next = '0;
      ms_next = '0;
    end
    else if (!done)
    begin
      if (pre_reg == PW'(MS_CYCLES - 1))
      begin
        pre_next = '0;
        ms_next = ms_reg + DW'(1);
      end
      else
      begin
        pre_next = pre_reg + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pre_reg <= '0;
      ms_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_next;
      ms_reg <= ms_next;
    end
  end

endmodule

// ### hdl/sapm_top.sv
`timescale 1ns/1ps
`include "sapm_cfg.svh"
module sapm_top import sapm_pkg::*; #(
  parameter int MS_CYCLES = `SAPM_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Safe input pin
  input wire logic activation_in_n,
  // Encoder positions, same clock
  input wire logic [`SAPM_POS_W-1:0] motor_pos,
  input wire logic [`SAPM_POS_W-1:0] external_encoder_port,
  // Safe outputs
  output logic range_ack_out,
  output logic brake_ramp_stop,
  output logic irq
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic sapm_reg_t sapm_dec(input logic [7:0] a);
    sapm_reg_t r;
    r = SAPM_R_NONE;
    case (a)
      `SAPM_OFF_CTRL: r = SAPM_R_CTRL;
      `SAPM_OFF_LOWER: r = SAPM_R_LOWER;
      `SAPM_OFF_UPPER: r = SAPM_R_UPPER;
      `SAPM_OFF_DELAY: r = SAPM_R_DELAY;
      `SAPM_OFF_TOL: r = SAPM_R_TOL;
      `SAPM_OFF_STATUS: r = SAPM_R_STATUS;
      `SAPM_OFF_IRQ_STAT: r = SAPM_R_IRQ_STAT;
      `SAPM_OFF_IRQ_MASK: r = SAPM_R_IRQ_MASK;
      default: r = SAPM_R_NONE;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  sapm_pos_t lower_reg;
  sapm_pos_t lower_next;
  sapm_pos_t upper_reg;
  sapm_pos_t upper_next;
  logic [`SAPM_DLY_W-1:0] delay_reg;
  logic [`SAPM_DLY_W-1:0] delay_next;
  logic [`SAPM_POS_W-1:0] tol_reg;
  logic [`SAPM_POS_W-1:0] tol_next;
  logic [`SAPM_IRQ_W-1:0] mask_reg;
  logic [`SAPM_IRQ_W-1:0] mask_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] rd_data;
  logic rd_clr;

  sapm_state_t state_reg;
  sapm_state_t state_next;
  logic ack_reg;
  logic ack_next;
  logic stop_reg;
  logic stop_next;
  logic lim_reg;
  logic lim_next;
  logic mis_reg;
  logic mis_next;
  logic [`SAPM_IRQ_W-1:0] stat_reg;
  logic [`SAPM_IRQ_W-1:0] stat_next;
  logic [`SAPM_IRQ_W-1:0] evt;
  logic irq_reg;
  logic irq_next;

  logic act_n_sync;
  logic active;
  logic in_band;
  logic permitted;
  logic mismatch;
  logic fault;
  logic mon;
  logic dly_done;
  logic signed [`SAPM_POS_W:0] diff;
  logic [`SAPM_POS_W:0] abs_diff;
  logic [`SAPM_DLY_W-1:0] wr_delay;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  // Idles deactivated so reset never looks like a request
  sapm_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_act_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d_in(activation_in_n),
    .d_out(act_n_sync)
  );

  // ------------------------------------------------------------
  // Start delay timer
  // ------------------------------------------------------------
  // Cleared outside delay
  sapm_delay_timer #(
    .MS_CYCLES(MS_CYCLES),
    .DW(`SAPM_DLY_W)
  ) u_delay (
    .clk_sys(clk_sys),
    .srst(srst),
    .clear(state_reg != SAPM_DELAY),
    .delay_ms(delay_reg),
    .done(dly_done)
  );

  // ------------------------------------------------------------
  // Position evaluation
  // ------------------------------------------------------------
  // Active low activation
  assign active = ctrl_reg[`SAPM_CTRL_PERM] | ~act_n_sync;
  assign in_band = ($signed(motor_pos) >= lower_reg) && ($signed(motor_pos) <= upper_reg);
  assign permitted = ctrl_reg[`SAPM_CTRL_INV] ? ~in_band : in_band;
  assign diff = $signed({motor_pos[`SAPM_POS_W-1], motor_pos})
              - $signed({external_encoder_port[`SAPM_POS_W-1], external_encoder_port});
  assign abs_diff = diff[`SAPM_POS_W] ? (`SAPM_POS_W+1)'(-diff) : (`SAPM_POS_W+1)'(diff);
  assign mismatch = abs_diff > {1'b0, tol_reg};
  assign fault = ~permitted | mismatch;
  assign mon = (state_reg == SAPM_MON) && active;

  // ------------------------------------------------------------
  // Register file and APB
  // ------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h00000000;
    case (sapm_dec(paddr))
      SAPM_R_CTRL: rd_data[2:0] = ctrl_reg;
      SAPM_R_LOWER: rd_data = {{8{lower_reg[23]}}, lower_reg};
      SAPM_R_UPPER: rd_data = {{8{upper_reg[23]}}, upper_reg};
      SAPM_R_DELAY: rd_data[`SAPM_DLY_W-1:0] = delay_reg;
      SAPM_R_TOL: rd_data[`SAPM_POS_W-1:0] = tol_reg;
      SAPM_R_STATUS:
      begin
        rd_data[`SAPM_ST_STATE_LO+1:`SAPM_ST_STATE_LO] = state_reg;
        rd_data[`SAPM_ST_ACK] = ack_reg;
        rd_data[`SAPM_ST_STOP] = stop_reg;
        rd_data[`SAPM_ST_LIMIT] = lim_reg;
        rd_data[`SAPM_ST_MISMATCH] = mis_reg;
        rd_data[`SAPM_ST_ACTIVE] = active;
      end
      SAPM_R_IRQ_STAT: rd_data[`SAPM_IRQ_W-1:0] = stat_reg;
      SAPM_R_IRQ_MASK: rd_data[`SAPM_IRQ_W-1:0] = mask_reg;
      default: rd_data = 32'h00000000;
    endcase
  end

  assign wr_delay = (pwdata > 32'(`SAPM_DLY_MAX_MS)) ? `SAPM_DLY_MAX_MS
                  : pwdata[`SAPM_DLY_W-1:0];

  always_comb
  begin
    ctrl_next = ctrl_reg;
    lower_next = lower_reg;
    upper_next = upper_reg;
    delay_next = delay_reg;
    tol_next = tol_reg;
    mask_next = mask_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    rd_clr = 1'b0;
    // Setup phase: answer one cycle later
    if (psel && !penable && !pready_reg)
    begin
      pready_next = 1'b1;
      prdata_next = rd_data;
      pslverr_next = (sapm_dec(paddr) == SAPM_R_NONE);
    end
    // Access phase completes here
    if (psel && penable && pready_reg)
    begin
      if (pwrite)
      begin
        case (sapm_dec(paddr))
          SAPM_R_CTRL: ctrl_next = pwdata[2:0];
          SAPM_R_LOWER: lower_next = pwdata[`SAPM_POS_W-1:0];
          SAPM_R_UPPER: upper_next = pwdata[`SAPM_POS_W-1:0];
          SAPM_R_DELAY: delay_next = wr_delay;
          SAPM_R_TOL: tol_next = pwdata[`SAPM_POS_W-1:0];
          SAPM_R_IRQ_MASK: mask_next = pwdata[`SAPM_IRQ_W-1:0];
          default: ctrl_next = ctrl_reg;
        endcase
      end
      else
      begin
        rd_clr = (sapm_dec(paddr) == SAPM_R_IRQ_STAT);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_reg <= `SAPM_CTRL_RST;
      lower_reg <= `SAPM_POS_RST;
      upper_reg <= `SAPM_POS_RST;
      delay_reg <= `SAPM_DLY_RST_MS;
      tol_reg <= `SAPM_TOL_RST;
      mask_reg <= `SAPM_IRQ_RST;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      delay_reg <= delay_next;
      tol_reg <= tol_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------
  // Supervision state machine and safe outputs
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SAPM_IDLE:
      begin
        if (active)
        begin
          state_next = ctrl_reg[`SAPM_CTRL_PERM] ? SAPM_MON : SAPM_DELAY;
        end
      end
      SAPM_DELAY:
      begin
        if (!active)
        begin
          state_next = SAPM_IDLE;
        end
        // Expiry or permanent mode starts checks
        else if (dly_done || ctrl_reg[`SAPM_CTRL_PERM])
        begin
          state_next = SAPM_MON;
        end
      end
      SAPM_MON:
      begin
        if (!active)
        begin
          state_next = SAPM_IDLE;
        end
      end
      default: state_next = SAPM_IDLE;
    endcase
    lim_next = mon & ~permitted;
    mis_next = mon & mismatch;
    // Ack only when monitoring and clean
    ack_next = mon & ~fault;
    stop_next = stop_reg | (mon & fault & ~ctrl_reg[`SAPM_CTRL_MON_ONLY]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_reg <= SAPM_IDLE;
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
      lim_reg <= 1'b0;
      mis_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      stop_reg <= stop_next;
      lim_reg <= lim_next;
      mis_reg <= mis_next;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  assign evt[`SAPM_IRQ_LIMIT] = lim_next & ~lim_reg;
  assign evt[`SAPM_IRQ_MISMATCH] = mis_next & ~mis_reg;
  assign evt[`SAPM_IRQ_START] = (state_next == SAPM_MON) && (state_reg != SAPM_MON);

  // Set beats read-clear so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < `SAPM_IRQ_W; gi++)
    begin : g_stat
      always_comb
      begin
        stat_next[gi] = (stat_reg[gi] & ~(rd_clr & prdata_reg[gi])) | evt[gi];
      end
    end
  endgenerate

  always_comb
  begin
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      stat_reg <= `SAPM_IRQ_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      stat_reg <= stat_next;
      irq_reg <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign range_ack_out = ack_reg;
  assign brake_ramp_stop = stop_reg;
  assign irq = irq_reg;

endmodule

// ### tb/sapm_checker_sva.sv
`timescale 1ns/1ps
`include "sapm_cfg.svh"
module sapm_checker #(
  parameter int MS_CYCLES = `SAPM_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic activation_in_n,
  input wire logic [`SAPM_POS_W-1:0] motor_pos,
  input wire logic [`SAPM_POS_W-1:0] external_encoder_port,
  input wire logic range_ack_out,
  input wire logic brake_ramp_stop,
  input wire logic irq
);
  logic [31:0] cfg [0:3];
  int act_cnt;
  logic in_band;
  logic in_zone;
  // ----------------------------------------
  // Shadow config
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < 3; i++)
        cfg[i] <= 32'h0;
      cfg[3] <= 32'h14;
    end
    else if (psel && penable && pready && pwrite && paddr[7:4] == 4'h0)
      cfg[paddr[3:2]] <= pwdata;
  end
  // Saturates so a long hold never wraps
  always_ff @(posedge clk_sys)
  begin
    if (srst || activation_in_n)
      act_cnt <= 0;
    else if (act_cnt < 1000000)
      act_cnt <= act_cnt + 1;
  end
  always_comb
  begin
    in_band = ($signed(motor_pos) >= $signed(cfg[1][23:0]))
      && ($signed(motor_pos) <= $signed(cfg[2][23:0]));
    in_zone = cfg[0][1] ? !in_band : in_band;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_pin_off;
    (!cfg[0][0] && activation_in_n)[*5];
  endsequence
  AST_PREADY_NEXT: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_SLVERR_MAP: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access without error");
  AST_ACK_IDLE: assert property (s_pin_off |=> !range_ack_out)
    else $error("ack while inactive");
  AST_ACK_DELAY: assert property (
    $rose(range_ack_out) && !cfg[0][0] |-> act_cnt >= cfg[3][16:0] * MS_CYCLES + 2)
    else $error("ack before start delay");
  AST_ACK_ZONE: assert property (
    range_ack_out |-> $past(in_zone))
    else $error("ack outside permitted zone");
  AST_STOP_LATCH: assert property (brake_ramp_stop |=> brake_ramp_stop)
    else $error("stop request dropped");
  AST_STOP_MON: assert property (
    cfg[0][2] && $past(cfg[0][2]) |-> !$rose(brake_ramp_stop))
    else $error("stop in monitor-only variant");
  AST_STOP_ACK: assert property ($rose(brake_ramp_stop) |-> !range_ack_out)
    else $error("stop with ack high");
endmodule
bind sapm_top sapm_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .activation_in_n(activation_in_n),
  .motor_pos(motor_pos), .external_encoder_port(external_encoder_port),
  .range_ack_out(range_ack_out), .brake_ramp_stop(brake_ramp_stop), .irq(irq)
);

// ### tb/sapm_partner.sv
`timescale 1ns/1ps
module sapm_partner (
  // Clock
  input wire logic clk_sys,
  // Bench commands
  input wire logic [23:0] pos_cmd,
  input wire logic [23:0] skew,
  input wire logic act_req,
  // Pins to block
  output logic activation_in_n,
  output logic [23:0] motor_pos,
  output logic [23:0] external_encoder_port
);
  initial
  begin
    activation_in_n = 1'b1;
    motor_pos = 24'h000000;
    external_encoder_port = 24'h000000;
  end
  // Skew stands in for a slipping second encoder
  always @(posedge clk_sys)
  begin
    activation_in_n <= !act_req;
    motor_pos <= pos_cmd;
    external_encoder_port <= pos_cmd + skew;
  end
endmodule

// ### tb/sapm_top_tb.sv
`timescale 1ns/1ps
module sapm_top_tb;
  logic clk_sys;
  logic srst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic act_n;
  logic [23:0] mpos;
  logic [23:0] epos;
  logic ack;
  logic stop;
  logic irq;
  logic [23:0] pos_cmd;
  logic [23:0] skew;
  logic act_req;
  logic [31:0] rd;
  logic err;
  int n_errors;
  int cmp_count;
  int cyc;
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, 32'h14, 32'h10, 32'h0};
  logic [31:0] tctl [9] = '{32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h6, 32'h6, 32'h6};
  logic [23:0] tpos [9] = '{24'h000064, 24'hFFFF9C, 24'h000065, 24'hFFFF9B, 24'h000000,
    24'h000000, 24'h000000, 24'h000065, 24'hFFFF9C};
  logic [23:0] tsk [9] = '{24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000011,
    24'h000010, 24'h000000, 24'h000000, 24'h000000};
  logic texp [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  sapm_top #(.MS_CYCLES(4)) DUT (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .activation_in_n(act_n),
    .motor_pos(mpos), .external_encoder_port(epos),
    .range_ack_out(ack), .brake_ramp_stop(stop), .irq(irq)
  );
  sapm_partner u_partner (
    .clk_sys(clk_sys), .pos_cmd(pos_cmd), .skew(skew), .act_req(act_req),
    .activation_in_n(act_n), .motor_pos(mpos), .external_encoder_port(epos)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits on pready, never a fixed count
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task drive(input logic [23:0] p, input logic [23:0] s, input logic a);
    @(posedge clk_sys);
    pos_cmd <= p;
    skew <= s;
    act_req <= a;
  endtask
  task summarize;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Run needs about 330 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos_cmd = 24'h0;
    skew = 24'h0;
    act_req = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    wt(20);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, rstv[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h04, 32'h00800000);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hFF800000);
    apb(1'b1, 8'h0C, 32'h00030D40);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0001D4C0);
    apb(1'b1, 8'h04, 32'hFFFFFF9C);
    apb(1'b1, 8'h08, 32'h64);
    apb(1'b1, 8'h0C, 32'h5);
    apb(1'b1, 8'h1C, 32'h7);
    apb(1'b1, 8'h00, 32'h4);
    drive(0, 0, 1);
    wt(6);
    chk(ack, 1'b0);
    wt(30);
    chk(ack, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h4);
    // Zone table, monitor-only so no stop
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, 8'h00, tctl[i]);
      drive(tpos[i], tsk[i], 1);
      wt(6);
      chk(ack, texp[i]);
      chk(stop, 1'b0);
    end
    apb(1'b1, 8'h00, 32'h4);
    drive(0, 0, 1);
    wt(4);
    chk(ack, 1'b1);
    drive(0, 0, 0);
    wt(6);
    chk(ack, 1'b0);
    drive(0, 0, 1);
    wt(16);
    drive(0, 0, 0);
    wt(6);
    drive(0, 0, 1);
    wt(14);
    chk(ack, 1'b0);
    wt(20);
    chk(ack, 1'b1);
    drive(0, 0, 0);
    apb(1'b1, 8'h00, 32'h5);
    wt(4);
    chk(ack, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    drive(24'hC8, 0, 0);
    wt(4);
    chk(stop, 1'b1);
    chk(ack, 1'b0);
    drive(0, 0, 0);
    wt(4);
    chk(stop, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000004E);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h7);
    wt(2);
    chk(irq, 1'b0);
    @(posedge clk_sys);
    srst <= 1'b1;
    wt(3);
    srst <= 1'b0;
    wt(2);
    chk(stop, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    wt(4);
    chk(irq, 1'b0);
    apb(1'b1, 8'h1C, 32'h4);
    wt(2);
    chk(irq, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h4);
    wt(2);
    chk(irq, 1'b0);
    summarize();
  end
endmodule
